// [core/iadd_defines.svh]
// constants for the add-one-to-memory instruction unit
// assumes an 8-bit data memory port and a 16-bit instruction word
//
// Operation
// RULE_01 - read location, add one, deliver sum
// RULE_02 - destination bit zero writes working register
// RULE_03 - destination bit one writes location back
// RULE_04 - access bit clear, extended, f<=95: indexed
// RULE_05 - update carry, half, negative, overflow, zero flags
`ifndef IADD_DEFINES_SVH
`define IADD_DEFINES_SVH

`define IADD_OPCODE        6'h0a
`define IADD_OPC_HI        15
`define IADD_OPC_LO        10
`define IADD_DEST_BIT      9
`define IADD_ACC_BIT       8
`define IADD_INDEX_LIMIT   8'h5f
`define IADD_W_RST         8'h00
`define IADD_FLAG_RST      5'h00
`define IADD_FLAG_C        0
`define IADD_FLAG_HALF     1
`define IADD_FLAG_Z        2
`define IADD_FLAG_OVF      3
`define IADD_FLAG_N        4
`define IADD_ACCESS_SPLIT  8'h60

`endif

// [core/iadd_pkg.sv]
// types for the add-one-to-memory instruction unit
// assumes nothing of its surroundings
package iadd_pkg;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_READ  = 4'b0010,
    ST_CALC  = 4'b0100,
    ST_WRITE = 4'b1000
  } iadd_state_t;
endpackage

// [core/iadd_alu.sv]
// incrementer with status flag generation
// assumes an 8-bit operand, purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "iadd_defines.svh"
module iadd_alu (
  input  wire logic [7:0] opnd,
  output logic      [7:0] sum,
  output logic      [4:0] flags
);
  wire [8:0] full = {1'b0, opnd} + 9'h001;   // RULE_01
  wire [4:0] low  = {1'b0, opnd[3:0]} + 5'h01;
  assign sum = full[7:0];
  // adding +1 can only overflow from 7fh
  assign flags[`IADD_FLAG_C]  = full[8];     // RULE_05
  assign flags[`IADD_FLAG_HALF] = low[4];    // RULE_05
  assign flags[`IADD_FLAG_Z]  = (full[7:0] == 8'h00); // RULE_05
  assign flags[`IADD_FLAG_OVF] = ~opnd[7] & full[7];  // RULE_05
  assign flags[`IADD_FLAG_N]  = full[7];     // RULE_05
endmodule
`default_nettype wire

// [core/iadd_unit.sv]
// executes the add-one-to-memory instruction over a data memory port
// assumes memory read data arrive the cycle after MEM_RD
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "iadd_defines.svh"
module iadd_unit (
  input  wire logic        MCLK,
  input  wire logic        RESET,
  input  wire logic        START,
  input  wire logic [15:0] INSTR,
  input  wire logic        EXT_EN,
  input  wire logic [7:0]  BANK,
  input  wire logic [11:0] INDEX_BASE,
  input  wire logic [7:0]  MEM_RDATA,
  output logic      [11:0] MEM_ADDR,
  output logic             MEM_RD,
  output logic             MEM_WR,
  output logic      [7:0]  MEM_WDATA,
  output logic      [7:0]  WREG,
  output logic      [4:0]  STATUS,
  output logic             DONE,
  output logic             ILLEGAL
);
  ////////////////////////////////////////////////////////////////////////
  iadd_pkg::iadd_state_t state_ff, nxt_state;
  logic [11:0] addr_ff;
  logic        dest_ff;
  logic [7:0]  opnd_ff;
  logic [7:0]  sum;
  logic [4:0]  flags;

  wire [7:0] f_fld     = INSTR[7:0];
  wire       acc_clear = ~INSTR[`IADD_ACC_BIT];
  wire       is_op     = INSTR[`IADD_OPC_HI:`IADD_OPC_LO] == `IADD_OPCODE;
  wire       indexed   = acc_clear & EXT_EN & (f_fld <= `IADD_INDEX_LIMIT); // RULE_04
  // access bank split at 60h when not indexed
  wire [11:0] acc_addr  = (f_fld < `IADD_ACCESS_SPLIT) ? {4'h0, f_fld} : {4'hf, f_fld};
  wire [11:0] idx_addr  = INDEX_BASE + {4'h0, f_fld};                     // RULE_04
  wire [11:0] bank_addr = {BANK[3:0], f_fld};
  wire [11:0] eff_addr  = indexed ? idx_addr : (acc_clear ? acc_addr : bank_addr);

  iadd_alu u_alu (
    .opnd  (opnd_ff),
    .sum   (sum),
    .flags (flags)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      iadd_pkg::ST_IDLE:  if (START && is_op) nxt_state = iadd_pkg::ST_READ;
      iadd_pkg::ST_READ:  nxt_state = iadd_pkg::ST_CALC;
      iadd_pkg::ST_CALC:  nxt_state = iadd_pkg::ST_WRITE;
      iadd_pkg::ST_WRITE: nxt_state = iadd_pkg::ST_IDLE;
      default:            nxt_state = iadd_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      state_ff  <= iadd_pkg::ST_IDLE;
      addr_ff   <= 12'h000;
      dest_ff   <= 1'b1;
      opnd_ff   <= 8'h00;
      MEM_ADDR  <= 12'h000;
      MEM_RD    <= 1'b0;
      MEM_WR    <= 1'b0;
      MEM_WDATA <= 8'h00;
      WREG      <= `IADD_W_RST;
      STATUS    <= `IADD_FLAG_RST;
      DONE      <= 1'b0;
      ILLEGAL   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      MEM_RD   <= 1'b0;
      MEM_WR   <= 1'b0;
      DONE     <= 1'b0;
      ILLEGAL  <= START & ~is_op & (state_ff == iadd_pkg::ST_IDLE);
      if (state_ff == iadd_pkg::ST_IDLE && START && is_op) begin
        addr_ff  <= eff_addr;
        dest_ff  <= INSTR[`IADD_DEST_BIT];
        MEM_ADDR <= eff_addr;
        MEM_RD   <= 1'b1;                          // RULE_01
      end
      // read data valid only the cycle after MEM_RD
      if (state_ff == iadd_pkg::ST_CALC) begin
        opnd_ff <= MEM_RDATA;
      end
      if (state_ff == iadd_pkg::ST_WRITE) begin
        STATUS <= flags;                           // RULE_05
        DONE   <= 1'b1;
        if (dest_ff) begin
          MEM_ADDR  <= addr_ff;                    // RULE_03
          MEM_WDATA <= sum;                        // RULE_03
          MEM_WR    <= 1'b1;                       // RULE_03
        end else begin
          WREG <= sum;                             // RULE_02
        end
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/iadd_checker.sv]
// port assertions for the add-one-to-memory unit
// assumes the bench holds INSTR and MEM_RDATA until DONE
`timescale 1ns/1ps
`default_nettype none
module iadd_checker (
  input wire logic        MCLK,
  input wire logic        RESET,
  input wire logic        START,
  input wire logic [15:0] INSTR,
  input wire logic        EXT_EN,
  input wire logic [11:0] INDEX_BASE,
  input wire logic [7:0]  MEM_RDATA,
  input wire logic [11:0] MEM_ADDR,
  input wire logic        MEM_RD,
  input wire logic        MEM_WR,
  input wire logic [7:0]  MEM_WDATA,
  input wire logic [7:0]  WREG,
  input wire logic [4:0]  STATUS,
  input wire logic        DONE,
  input wire logic        ILLEGAL
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  sequence s_finish;
    ##3 DONE;
  endsequence
  a_read_to_done: assert property (MEM_RD |-> s_finish) else $error("late done");
  a_wb_value: assert property (MEM_WR |-> MEM_WDATA == MEM_RDATA + 8'h01) else $error("wb");
  a_wreg_value: assert property (DONE && !INSTR[9] |-> WREG == MEM_RDATA + 8'h01)
    else $error("wreg");
  a_dest_select: assert property (DONE |-> MEM_WR == INSTR[9]) else $error("dest");
  a_same_location: assert property (MEM_WR |-> MEM_ADDR == $past(MEM_ADDR, 3))
    else $error("addr");
  a_indexed_addr: assert property (MEM_RD && !INSTR[8] && EXT_EN && INSTR[7:0] <= 8'h5f
    |-> MEM_ADDR == INDEX_BASE + {4'h0, INSTR[7:0]}) else $error("index");
  a_zero_carry: assert property (DONE |-> STATUS[2] == (MEM_RDATA == 8'hff)
    && STATUS[0] == STATUS[2]) else $error("flags");
  a_illegal_pulse: assert property (ILLEGAL |-> $past(START) &&
    $past(INSTR[15:10]) != 6'h0a) else $error("illegal");
endmodule
bind iadd_unit iadd_checker u_chk (
  .MCLK       (MCLK),
  .RESET      (RESET),
  .START      (START),
  .INSTR      (INSTR),
  .EXT_EN     (EXT_EN),
  .INDEX_BASE (INDEX_BASE),
  .MEM_RDATA  (MEM_RDATA),
  .MEM_ADDR   (MEM_ADDR),
  .MEM_RD     (MEM_RD),
  .MEM_WR     (MEM_WR),
  .MEM_WDATA  (MEM_WDATA),
  .WREG       (WREG),
  .STATUS     (STATUS),
  .DONE       (DONE),
  .ILLEGAL    (ILLEGAL)
);
`default_nettype wire

// [testbench/increment_file_register_op_tb.sv]
// bench for the add-one-to-memory unit
// assumes an answer within ten cycles of START
`timescale 1ns/1ps
`default_nettype none
module increment_file_register_op_tb;
  logic        mclk = 0, reset = 1, start = 0, ext_en = 0;
  logic [15:0] instr = 16'h0000;
  logic [7:0]  rdata = 8'h00, wdata, wreg;
  logic [11:0] addr;
  logic [4:0]  status;
  logic        rd, wr, done, illegal;
  int          n_mismatch = 0, checked = 0;
  always #2.5 mclk = ~mclk;
  iadd_unit u_dut (.MCLK(mclk), .RESET(reset), .START(start), .INSTR(instr), .EXT_EN(ext_en),
    .BANK(8'h03), .INDEX_BASE(12'h200), .MEM_RDATA(rdata), .MEM_ADDR(addr), .MEM_RD(rd),
    .MEM_WR(wr), .MEM_WDATA(wdata), .WREG(wreg), .STATUS(status), .DONE(done),
    .ILLEGAL(illegal));
  ////////////////////////////////////////
  task final_report;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // memory data held through DONE so the checker can see it
  task automatic run(input logic d, a, e, input logic [7:0] f, v);
    logic [7:0]  s;
    logic [11:0] ea;
    int          i;
    s = v + 8'h01;
    if (!a && e && f <= 8'h5f) ea = 12'h200 + {4'h0, f};
    else if (!a) ea = (f < 8'h60) ? {4'h0, f} : {4'hf, f};
    else ea = {4'h3, f};
    @(posedge mclk);
    instr <= {6'h0a, d, a, f};
    ext_en <= e;
    rdata <= v;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    for (i = 0; i < 10 && done !== 1'b1; i++) @(negedge mclk);
    if (i == 10) begin
      n_mismatch++;
      final_report;
    end
    chk({4'h0, d ? wdata : wreg}, {4'h0, s});
    chk({11'h000, wr}, {11'h000, d});
    chk(addr, ea);
    chk({7'h00, status}, {7'h00, s[7], v == 8'h7f, s == 8'h00, v[3:0] == 4'hf, v == 8'hff});
  endtask
  // wrong opcode: one-cycle refusal pulse, no memory access
  task automatic bad_op;
    @(posedge mclk);
    instr <= {6'h0b, 2'b10, 8'h10};
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    @(negedge mclk);
    chk({11'h000, illegal}, 12'h001);
    chk({11'h000, rd}, 12'h000);
    @(negedge mclk);
    chk({11'h000, illegal}, 12'h000);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    run(1'b0, 1'b1, 1'b0, 8'h10, 8'hff);
    bad_op;
    run(1'b1, 1'b0, 1'b1, 8'h5f, 8'h7f);
    run(1'b1, 1'b0, 1'b1, 8'h60, 8'h0f);
    run(1'b0, 1'b0, 1'b1, 8'h00, 8'h80);
    final_report;
  end
endmodule
`default_nettype wire
